//--- hw/psr_pkg.sv
// Package for the pressure readout two-wire slave: constants, states, carriers.
// Assumes a single 20 MHz reference clock and no software-visible registers.
package psr_pkg;
    // Reference clock period in ns
    localparam int CLK_PERIOD_NS = 50;
    // Refresh interval of the corrected pressure value, in us
    localparam int REFRESH_US = 250;
    // Refresh interval in reference clock cycles, rounded down
    localparam int REFRESH_CYC = (REFRESH_US * 1000) / CLK_PERIOD_NS;
    // Primary slave address, upper seven bits of the address byte
    localparam logic [6:0] ADDR_PRIMARY = 7'h78;
    // Secondary address default; value is arbitrary, set by factory straps
    localparam logic [6:0] ADDR_SECOND_DEF = 7'h00;
    // Bits per byte and widths
    localparam int BYTE_BITS = 8;
    localparam int PRESS_BITS = 15;
    localparam int SAMPLE_BITS = 12;
    // Last bit index of a byte, counted MSB first
    localparam logic [3:0] BIT_LAST = 4'h7;
    // Output FIFO depth
    localparam int FIFO_DEPTH = 16;

    // Slave protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ADDR_ACK = 3'b010,
        ST_RX = 3'b011,
        ST_RX_ACK = 3'b100,
        ST_TX = 3'b101,
        ST_TX_ACK = 3'b110
    } psr_state_e;

    // A pressure word, value only
    typedef struct packed {
        logic [PRESS_BITS-1:0] value;
    } psr_word_s;

    // Bus events seen from the sampled lines
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
    } psr_evt_s;
endpackage : psr_pkg

//--- hw/psr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
module psr_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // Honest full and empty from the fill count
    assign in_ready = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop)
            begin
                count_ff <= count_ff + 1'b1;
            end
            else if (pop && !push)
            begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    // Never overfilled nor underflowed
    a_fifo_no_overrun: assert property (@(posedge clk) disable iff (!rst_n)
        count_ff <= (AW+1)'(DEPTH))
        else $error("FIFO count beyond depth");
endmodule : psr_fifo

//--- hw/psr_sampler.sv
// Pressure sample source: produces a 12-bit corrected value on a fixed period.
// Assumes the raw converter value arrives synchronous to the reference clock.
`timescale 1ns/100ps
module psr_sampler #(
    parameter int PERIOD = psr_pkg::REFRESH_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [psr_pkg::SAMPLE_BITS-1:0] raw,
    output psr_pkg::psr_word_s word,
    output logic word_valid,
    input wire logic word_ready
);
    localparam int CW = $clog2(PERIOD + 1);
    logic [CW-1:0] tick_ff;
    logic valid_ff;
    psr_pkg::psr_word_s word_ff;

    assign word = word_ff;
    assign word_valid = valid_ff;

    // Refresh divider, free running regardless of bus traffic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_ff <= '0;
        end
        else if (tick_ff == CW'(PERIOD - 1))
        begin
            tick_ff <= '0;
        end
        else
        begin
            tick_ff <= tick_ff + 1'b1;
        end
    end

    // Offer a new sample each period; a stalled sink keeps the newest one
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid_ff <= 1'b0;
            word_ff <= '0;
        end
        else if (tick_ff == CW'(PERIOD - 1))
        begin
            valid_ff <= 1'b1;
            word_ff.value <= {{(psr_pkg::PRESS_BITS - psr_pkg::SAMPLE_BITS){1'b0}}, raw};
        end
        else if (word_ready)
        begin
            valid_ff <= 1'b0;
        end
    end

    a_refresh_period: assert property (@(posedge clk) disable iff (!rst_n)
        (tick_ff == CW'(PERIOD - 1)) |=> valid_ff)
        else $error("Refresh did not offer a sample");
endmodule : psr_sampler

//--- hw/psr_slave.sv
// Two-wire slave port returning the latest pressure word on reads.
// Assumes SCL and SDA arrive from pins, open drain, sampled by REF_CLK.
`timescale 1ns/100ps
module psr_slave #(
    parameter int REFRESH_CYCLES = psr_pkg::REFRESH_CYC,
    parameter logic [6:0] PRIMARY_ADDR = psr_pkg::ADDR_PRIMARY
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [6:0] SECOND_ADDR,
    input wire logic SECOND_ADDR_EN,
    input wire logic [psr_pkg::SAMPLE_BITS-1:0] RAW_SAMPLE,
    output logic BUSY
);
    logic [2:0] scl_sync_ff;
    logic [2:0] sda_sync_ff;
    psr_pkg::psr_evt_s evt;
    psr_pkg::psr_state_e state_ff;
    psr_pkg::psr_state_e nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic byte_sel_ff;
    logic sda_oe_ff;
    logic busy_ff;
    logic [psr_pkg::PRESS_BITS-1:0] latch_ff;
    logic [psr_pkg::PRESS_BITS-1:0] cur_ff;
    psr_pkg::psr_word_s smp_word;
    logic smp_valid;
    logic smp_ready;
    psr_pkg::psr_word_s fifo_word;
    logic fifo_valid;
    logic fifo_ready;
    logic addr_hit;
    logic [7:0] tx_byte;
    logic [2:0] tx_idx;
    logic ack_ok_ff;

    // Address byte sees one extra SCL fall right after start, so it counts one further
    localparam logic [3:0] ADDR_LAST = psr_pkg::BIT_LAST + 4'h1;

    // Pressure sample generator
    psr_sampler #(
        .PERIOD(REFRESH_CYCLES)
    ) u_sampler (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .raw(RAW_SAMPLE),
        .word(smp_word),
        .word_valid(smp_valid),
        .word_ready(smp_ready)
    );

    // Sample buffer between converter and output register
    psr_fifo #(
        .WIDTH(psr_pkg::PRESS_BITS),
        .DEPTH(psr_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .in_data(smp_word),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .out_data(fifo_word),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    // Output register drains only while no read is in flight
    assign fifo_ready = (state_ff != psr_pkg::ST_TX) && (state_ff != psr_pkg::ST_TX_ACK);

    // Output register update
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cur_ff <= '0;
        end
        else if (fifo_valid && fifo_ready)
        begin
            cur_ff <= fifo_word.value;
        end
    end

    // Two-stage synchronisers plus one history stage for edge finding
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], SCL_IN};
            sda_sync_ff <= {sda_sync_ff[1:0], SDA_IN};
        end
    end

    // Bus events from stages two and three only
    always_comb
    begin
        evt.start = scl_sync_ff[1] && scl_sync_ff[2] && sda_sync_ff[2] && !sda_sync_ff[1];
        evt.stop = scl_sync_ff[1] && scl_sync_ff[2] && !sda_sync_ff[2] && sda_sync_ff[1];
        evt.scl_rise = scl_sync_ff[1] && !scl_sync_ff[2];
        evt.scl_fall = !scl_sync_ff[1] && scl_sync_ff[2];
    end

    // Address match against primary and optional secondary
    assign addr_hit = (shift_ff[7:1] == PRIMARY_ADDR)
        || (SECOND_ADDR_EN && (shift_ff[7:1] == SECOND_ADDR));

    // Byte being sent: zero MSB then high part, then low byte from the ack slot on
    assign tx_byte = (byte_sel_ff || state_ff == psr_pkg::ST_TX_ACK) ? latch_ff[7:0]
        : {1'b0, latch_ff[14:8]};
    // Bit to drive at the next SCL fall: MSB on entry, then one lower per fall
    assign tx_idx = (state_ff == psr_pkg::ST_TX) ? 3'(psr_pkg::BIT_LAST - 4'h1 - bit_cnt_ff)
        : 3'(psr_pkg::BIT_LAST);

    // Next protocol state, advanced on SCL falling edges
    always_comb
    begin
        nxt_state = state_ff;
        if (evt.stop)
        begin
            nxt_state = psr_pkg::ST_IDLE;
        end
        else if (evt.start)
        begin
            nxt_state = psr_pkg::ST_ADDR;
        end
        else if (evt.scl_fall)
        begin
            case (state_ff)
                psr_pkg::ST_IDLE:
                begin
                    nxt_state = psr_pkg::ST_IDLE;
                end
                psr_pkg::ST_ADDR:
                begin
                    if (bit_cnt_ff == ADDR_LAST)
                    begin
                        nxt_state = addr_hit ? psr_pkg::ST_ADDR_ACK : psr_pkg::ST_IDLE;
                    end
                end
                psr_pkg::ST_ADDR_ACK:
                begin
                    nxt_state = shift_ff[0] ? psr_pkg::ST_TX : psr_pkg::ST_RX;
                end
                psr_pkg::ST_RX:
                begin
                    if (bit_cnt_ff == psr_pkg::BIT_LAST)
                    begin
                        nxt_state = psr_pkg::ST_RX_ACK;
                    end
                end
                psr_pkg::ST_RX_ACK:
                begin
                    nxt_state = psr_pkg::ST_RX;
                end
                psr_pkg::ST_TX:
                begin
                    if (bit_cnt_ff == psr_pkg::BIT_LAST)
                    begin
                        nxt_state = psr_pkg::ST_TX_ACK;
                    end
                end
                psr_pkg::ST_TX_ACK:
                begin
                    // Master ack after the first byte fetches the low byte, else release
                    nxt_state = (ack_ok_ff && !byte_sel_ff) ? psr_pkg::ST_TX
                        : psr_pkg::ST_IDLE;
                end
                default:
                begin
                    nxt_state = psr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_ff <= psr_pkg::ST_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Acknowledge seen from the master in the ninth clock
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ack_ok_ff <= 1'b0;
        end
        else if (state_ff == psr_pkg::ST_TX_ACK && evt.scl_rise)
        begin
            ack_ok_ff <= !sda_sync_ff[1];
        end
    end

    // Bit counter, reset by start and at each byte boundary
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            bit_cnt_ff <= '0;
        end
        else if (evt.start || nxt_state != state_ff || state_ff == psr_pkg::ST_TX_ACK)
        begin
            bit_cnt_ff <= '0;
        end
        else if (evt.scl_fall)
        begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
        end
    end

    // Receive shifter, MSB first, sampled on SCL rise
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            shift_ff <= '0;
        end
        else if (evt.scl_rise && (state_ff == psr_pkg::ST_ADDR || state_ff == psr_pkg::ST_RX))
        begin
            shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
        end
    end

    // Byte selector and snapshot of the value for the whole read
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            byte_sel_ff <= 1'b0;
            latch_ff <= '0;
        end
        else if (state_ff == psr_pkg::ST_ADDR_ACK)
        begin
            byte_sel_ff <= 1'b0;
            latch_ff <= cur_ff;
        end
        else if (state_ff == psr_pkg::ST_TX_ACK && evt.scl_fall)
        begin
            byte_sel_ff <= 1'b1;
        end
    end

    // SDA drive, changed after an SCL fall and released on start or stop
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            sda_oe_ff <= 1'b0;
        end
        else if (evt.start || evt.stop)
        begin
            sda_oe_ff <= 1'b0;
        end
        else if (evt.scl_fall)
        begin
            case (nxt_state)
                psr_pkg::ST_ADDR_ACK, psr_pkg::ST_RX_ACK:
                begin
                    sda_oe_ff <= 1'b1;
                end
                psr_pkg::ST_TX:
                begin
                    sda_oe_ff <= !tx_byte[tx_idx];
                end
                default:
                begin
                    sda_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Busy flag between start and stop
    always_ff @(posedge REF_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            busy_ff <= 1'b0;
        end
        else if (evt.start)
        begin
            busy_ff <= 1'b1;
        end
        else if (evt.stop)
        begin
            busy_ff <= 1'b0;
        end
    end

    assign SDA_OUT = 1'b0;
    assign SDA_OE = sda_oe_ff;
    assign BUSY = busy_ff;

    a_idle_released: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (state_ff == psr_pkg::ST_IDLE) |-> !sda_oe_ff)
        else $error("SDA driven while idle");
    a_stop_ends: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        evt.stop |=> (state_ff == psr_pkg::ST_IDLE))
        else $error("Stop did not end transaction");
    a_start_addr: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (evt.start && !evt.stop) |=> (state_ff == psr_pkg::ST_ADDR))
        else $error("Start not detected");
    a_sda_stable_high: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (scl_sync_ff[1] && scl_sync_ff[2]) |=> $stable(sda_oe_ff))
        else $error("SDA changed while SCL high");
    a_nomatch_noack: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (state_ff == psr_pkg::ST_ADDR && evt.scl_fall && bit_cnt_ff == ADDR_LAST
         && !addr_hit && !evt.start && !evt.stop) |=> !sda_oe_ff)
        else $error("Acknowledged foreign address");
    a_addr_ack_low: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (state_ff == psr_pkg::ST_ADDR_ACK) |-> sda_oe_ff)
        else $error("Matching address not acknowledged");
    a_first_msb_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (state_ff == psr_pkg::ST_TX && !byte_sel_ff && bit_cnt_ff == '0
         && $past(evt.scl_fall)) |-> sda_oe_ff)
        else $error("First data bit not zero");
    a_nack_release: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (state_ff == psr_pkg::ST_TX_ACK && evt.scl_fall && !ack_ok_ff && !evt.start)
        |=> !sda_oe_ff)
        else $error("Kept sending after missed acknowledge");
endmodule : psr_slave

//--- tb/psr_master.sv
// Two-wire bus master model that clocks reads and writes into the slave.
// Assumes an open-drain data line resolved by the testbench with a pull-up.
`timescale 1ns/100ps
module psr_master (
    input wire logic clk,
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    // Count of data changes seen while the clock was high
    int wobble = 0;

    // Both lines released at start of time
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One pulse: 5 cycles low, then 3 high with data watched throughout
    // Bit period is 8 clocks, faster than a real bus; the slave only needs SCL under 1/8 clock
    task automatic bit_cyc(input logic b, output logic got);
        scl <= 1'b0;
        tick(1);
        sda_oe <= ~b;
        tick(4);
        scl <= 1'b1;
        @(negedge clk);
        got = sda;
        repeat (2)
        begin
            @(negedge clk);
            if (sda !== got) wobble++;
        end
        @(posedge clk);
    endtask : bit_cyc

    // Data falls while clock high; also serves as repeated start
    task automatic start();
        scl <= 1'b0;
        tick(1);
        sda_oe <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_oe <= 1'b1;
        tick(4);
    endtask : start

    // Data rises while clock high
    task automatic stop();
        scl <= 1'b0;
        tick(1);
        sda_oe <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sda_oe <= 1'b0;
        tick(4);
    endtask : stop

    // Eight bits MSB first, then the acknowledge pulse
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bit_cyc(d[i], g);
        bit_cyc(1'b1, g);
        ack = ~g;
    endtask : wr_byte

    // Eight bits in, then our acknowledge or its absence
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(1'b1, g);
            d[i] = g;
        end
        bit_cyc(~ack, g);
    endtask : rd_byte

    // Clock held low so the slave gets its chance to release
    task automatic low_hold();
        scl <= 1'b0;
        tick(1);
        sda_oe <= 1'b0;
        tick(5);
    endtask : low_hold
endmodule : psr_master

//--- tb/testbench.sv
// Self-checking bench for the pressure readout slave with a bus master model.
// Assumes the slave refresh period is shortened to 20 clocks for simulation.
`timescale 1ns/100ps
module testbench;
    localparam logic [6:0] PRI = psr_pkg::ADDR_PRIMARY;
    logic ref_clk;
    logic rst_n;
    logic [6:0] second_addr;
    logic second_en;
    logic [11:0] raw;
    logic scl;
    logic m_oe;
    logic sda_out;
    logic sda_oe;
    logic busy;
    wire logic sda_line;
    int err_total = 0;
    int total_checks = 0;
    int seed = 32'h249c3611;

    // Open-drain data line with pull-up
    assign sda_line = ~(sda_oe | m_oe);

    psr_slave #(.REFRESH_CYCLES(20)) dut (.REF_CLK(ref_clk), .RST_N(rst_n), .SCL_IN(scl),
        .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SECOND_ADDR(second_addr),
        .SECOND_ADDR_EN(second_en), .RAW_SAMPLE(raw), .BUSY(busy));

    psr_master m (.clk(ref_clk), .scl(scl), .sda_oe(m_oe), .sda(sda_line));

    // 20 MHz reference clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] exp_hi(input logic [11:0] v);
        return {4'h0, v[11:8]};
    endfunction : exp_hi

    function automatic logic [7:0] exp_lo(input logic [11:0] v);
        return v[7:0];
    endfunction : exp_lo

    task automatic chk(input string what, input logic [7:0] expv, input logic [7:0] got);
        total_checks++;
        if (got !== expv)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, expv, got);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out

    // New sample, then enough refresh periods to flush the buffer
    task automatic set_raw(input logic [11:0] v);
        raw <= v;
        repeat (800) @(posedge ref_clk);
    endtask : set_raw

    task automatic rd_txn(input logic [6:0] a, input logic [11:0] v, input logic both);
        logic ack;
        logic [7:0] b;
        m.start();
        chk("busy", 8'h01, {7'h00, busy});
        m.wr_byte({a, 1'b1}, ack);
        chk("addr ack", 8'h01, {7'h00, ack});
        m.rd_byte(both, b);
        chk("high byte", exp_hi(v), b);
        if (both)
        begin
            m.rd_byte(1'b0, b);
            chk("low byte", exp_lo(v), b);
        end
        m.low_hold();
        chk("released", 8'h00, {7'h00, sda_oe});
    endtask : rd_txn

    task automatic end_txn();
        m.stop();
        chk("busy", 8'h00, {7'h00, busy});
        chk("idle oe", 8'h00, {7'h00, sda_oe});
        chk("sda out", 8'h00, {7'h00, sda_out});
    endtask : end_txn

    task automatic addr_only(input logic [6:0] a, input logic expect_ack);
        logic ack;
        m.start();
        m.wr_byte({a, 1'b1}, ack);
        chk("addr ack", {7'h00, expect_ack}, {7'h00, ack});
        end_txn();
    endtask : addr_only

    // Main sequence
    initial
    begin
        logic [11:0] v;
        logic [6:0] sa;
        logic [7:0] d;
        logic ack;
        logic [11:0] vals[4];
        logic [6:0] bad[4];
        int r;
        rst_n = 1'b0;
        second_addr = 7'h00;
        second_en = 1'b0;
        raw = 12'h000;
        vals = '{12'h000, 12'hFFF, 12'h800, 12'h0FF};
        bad = '{7'h79, 7'h38, 7'h70, 7'h00};
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk("idle oe", 8'h00, {7'h00, sda_oe});
        chk("busy", 8'h00, {7'h00, busy});
        $display("test idle done");
        // Corner values first, then random ones
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            v = (i < 4) ? vals[i] : r[11:0];
            set_raw(v);
            rd_txn(PRI, v, 1'b1);
            end_txn();
        end
        $display("test reads done");
        // Reads joined by repeated starts, last one refused by the master
        r = $random(seed);
        v = r[11:0];
        set_raw(v);
        rd_txn(PRI, v, 1'b1);
        rd_txn(PRI, v, 1'b1);
        rd_txn(PRI, v, 1'b0);
        end_txn();
        $display("test repeat done");
        // Addresses that match nothing
        for (int i = 0; i < 4; i++) addr_only(bad[i], 1'b0);
        $display("test refused done");
        // Secondary address on, then off again
        r = $random(seed);
        sa = {1'b0, r[5:0]};
        v = r[19:8];
        second_addr <= sa;
        second_en <= 1'b1;
        set_raw(v);
        rd_txn(sa, v, 1'b1);
        end_txn();
        rd_txn(PRI, v, 1'b1);
        end_txn();
        second_en <= 1'b0;
        @(posedge ref_clk);
        addr_only(sa, 1'b0);
        $display("test second done");
        // Write direction: address and data both acknowledged
        r = $random(seed);
        d = r[7:0];
        m.start();
        m.wr_byte({PRI, 1'b0}, ack);
        chk("write ack", 8'h01, {7'h00, ack});
        m.wr_byte(d, ack);
        chk("data ack", 8'h01, {7'h00, ack});
        end_txn();
        chk("stable", 8'h00, m.wobble[7:0]);
        $display("test write done");
        close_out();
    end

    // Watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        err_total++;
        $display("[ERR] run time expected under limit seen over");
        close_out();
    end
endmodule : testbench
